//--- motion_activity_detector_defs.vh
`ifndef MOTION_ACTIVITY_DETECTOR_DEFS_VH
`define MOTION_ACTIVITY_DETECTOR_DEFS_VH

// register byte offsets
`define REG_CTRL           8'h00
`define REG_ACT_THRESH     8'h04
`define REG_ACT_TIME       8'h08
`define REG_INACT_THRESH   8'h0c
`define REG_INACT_TIME     8'h10
`define REG_INT_MAP        8'h14
`define REG_STATUS         8'h18

// control register fields
`define CTRL_ACT_EN        0
`define CTRL_ACT_REF       1
`define CTRL_INACT_EN      2
`define CTRL_INACT_REF     3
`define CTRL_LINK          4
`define CTRL_NOISE_LO      5
`define CTRL_NOISE_HI      6
`define CTRL_FILTER_BW     7
`define CTRL_MEASURE       8
`define CTRL_WAKEUP        9
`define CTRL_W             10

// status and interrupt map fields
`define ST_ACT             0
`define ST_INACT           1
`define ST_AWAKE           2
`define ST_W               3

// reset values
`define CTRL_RESET         10'h000
`define ACT_THRESH_RESET   11'h000
`define ACT_TIME_RESET     8'h00
`define INACT_THRESH_RESET 11'h000
`define INACT_TIME_RESET   16'h0000
`define INT_MAP_RESET      3'h0
`define AWAKE_RESET        1'b0

// filter bandwidth select encodings
`define BW_QUARTER         1'b0
`define BW_HALF            1'b1

// noise mode encodings
`define NOISE_NORMAL       2'h0
`define NOISE_LOW          2'h1
`define NOISE_ULTRALOW     2'h2

// longest activity duration at the slowest output rate
`define ACT_TIME_MAX_S     20
`define SLOWEST_ODR_MHZ    12500

`endif

//--- axis_deviation_check.v
`timescale 1ns/10ps
`default_nettype none

module axis_deviation_check #(
  parameter SW = 12,
  parameter TW = 11
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // sample path
  input  wire          sample_strobe,
  input  wire          capture,
  input  wire [SW-1:0] sample,
  // configuration
  input  wire          referenced,
  input  wire [TW-1:0] threshold,
  // result
  output wire          exceed
);

  reg  [SW-1:0] ref_q;
  wire [SW:0]   s_ext;
  wire [SW:0]   r_ext;
  wire [SW:0]   diff;
  wire [SW:0]   mag;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= {SW{1'b0}};
    end else if (sample_strobe && capture) begin
      ref_q <= sample;
    end
  end

  assign s_ext = {sample[SW-1], sample};
  // absolute mode measures against zero, referenced against the stored orientation
  assign r_ext = referenced ? {ref_q[SW-1], ref_q} : {(SW+1){1'b0}};
  assign diff  = s_ext - r_ext;
  assign mag   = diff[SW] ? (~diff + {{SW{1'b0}}, 1'b1}) : diff;
  assign exceed = mag > {{(SW+1-TW){1'b0}}, threshold};

endmodule

`default_nettype wire

//--- sample_run_counter.v
`timescale 1ns/10ps
`default_nettype none

module sample_run_counter #(
  parameter CW = 8
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // sample qualification
  input  wire          sample_strobe,
  input  wire          armed,
  input  wire          qualify,
  input  wire [CW-1:0] target,
  // detection
  output reg           hit
);

  reg  [CW-1:0] count_q;
  wire [CW:0]   need;
  wire [CW:0]   next_count;

  // a target of zero means a single sample, no timer
  assign need       = (target == {CW{1'b0}}) ? {{CW{1'b0}}, 1'b1} : {1'b0, target};
  assign next_count = {1'b0, count_q} + {{CW{1'b0}}, 1'b1};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {CW{1'b0}};
      hit     <= 1'b0;
    end else if (!armed) begin
      count_q <= {CW{1'b0}};
      hit     <= 1'b0;
    end else if (sample_strobe) begin
      if (!qualify) begin
        count_q <= {CW{1'b0}};
        hit     <= 1'b0;
      end else if (next_count >= need) begin
        count_q <= {CW{1'b0}};
        hit     <= 1'b1;
      end else begin
        count_q <= next_count[CW-1:0];
        hit     <= 1'b0;
      end
    end else begin
      hit <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- motion_activity_detector.v
// Decided for this implementation: the address-and-strobe port and the address map.
`include "motion_activity_detector_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module motion_activity_detector #(
  parameter SW  = 12,
  parameter TW  = 11,
  parameter AW  = 8,
  parameter ITW = 16
) (
  // clock and reset
  input  wire          REF_CLK,
  input  wire          RSTN,
  // register port
  input  wire [7:0]    ADDR,
  input  wire [31:0]   WDATA,
  input  wire          WR,
  input  wire          RD,
  output wire [31:0]   RDATA,
  // converted samples at the output data rate
  input  wire          SAMPLE_VALID,
  input  wire [SW-1:0] SAMPLE_X,
  input  wire [SW-1:0] SAMPLE_Y,
  input  wire [SW-1:0] SAMPLE_Z,
  // front end configuration
  output wire          FILTER_BANDWIDTH_SELECT,
  output wire [1:0]    NOISE_MODE,
  output wire          MEASURE_EN,
  output wire          WAKEUP_EN,
  // detection results
  output wire          INT_REQ,
  output wire          AWAKE
);

  // activity duration needed at the slowest rate, in samples
  localparam ACT_TIME_MAX_SAMPLES = (`ACT_TIME_MAX_S * `SLOWEST_ODR_MHZ) / 1000;

  reg            rst_meta_q;
  reg            rst_sync_q;
  wire           rst_n;

  reg [`CTRL_W-1:0] ctrl_q;
  reg [TW-1:0]      act_thr_q;
  reg [AW-1:0]      act_time_q;
  reg [TW-1:0]      inact_thr_q;
  reg [ITW-1:0]     inact_time_q;
  reg [`ST_W-1:0]   int_map_q;
  reg               act_flag_q;
  reg               inact_flag_q;
  reg               awake_q;
  reg [31:0]        rdata_q;
  reg [31:0]        rdata_d;

  reg               inact_turn_q;
  reg               act_live_q;
  reg               inact_live_q;
  reg               act_cap_q;
  reg               inact_cap_q;

  wire              act_en;
  wire              inact_en;
  wire              link_en;
  wire              running;
  wire              wake_mode;
  wire              act_armed;
  wire              inact_armed;
  wire              act_live;
  wire              inact_live;
  wire              act_start;
  wire              inact_start;
  wire [2:0]        act_exceed;
  wire [2:0]        inact_exceed;
  wire [3*SW-1:0]   samples;
  wire              act_qualify;
  wire              inact_qualify;
  wire [AW-1:0]     act_target;
  wire              act_hit;
  wire              inact_hit;
  wire              wr_ctrl;
  wire              rd_status;
  wire [`ST_W-1:0]  status;

  // reset release through two flops; the input reset still asserts at once
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // register writes
  assign wr_ctrl   = WR && (ADDR == `REG_CTRL);
  assign rd_status = RD && (ADDR == `REG_STATUS);

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q       <= `CTRL_RESET;
      act_thr_q    <= `ACT_THRESH_RESET;
      act_time_q   <= `ACT_TIME_RESET;
      inact_thr_q  <= `INACT_THRESH_RESET;
      inact_time_q <= `INACT_TIME_RESET;
      int_map_q    <= `INT_MAP_RESET;
    end else if (WR) begin
      case (ADDR)
        `REG_CTRL:         ctrl_q       <= WDATA[`CTRL_W-1:0];
        `REG_ACT_THRESH:   act_thr_q    <= WDATA[TW-1:0];
        `REG_ACT_TIME:     act_time_q   <= WDATA[AW-1:0];
        `REG_INACT_THRESH: inact_thr_q  <= WDATA[TW-1:0];
        `REG_INACT_TIME:   inact_time_q <= WDATA[ITW-1:0];
        `REG_INT_MAP:      int_map_q    <= WDATA[`ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  assign act_en    = ctrl_q[`CTRL_ACT_EN];
  assign inact_en  = ctrl_q[`CTRL_INACT_EN];
  assign link_en   = ctrl_q[`CTRL_LINK];
  // standby when neither mode bit is set; wakeup wins if both are
  assign wake_mode = ctrl_q[`CTRL_WAKEUP];
  assign running   = ctrl_q[`CTRL_MEASURE] | wake_mode;

  assign FILTER_BANDWIDTH_SELECT = ctrl_q[`CTRL_FILTER_BW];
  assign NOISE_MODE              = {ctrl_q[`CTRL_NOISE_HI], ctrl_q[`CTRL_NOISE_LO]};
  assign MEASURE_EN              = ctrl_q[`CTRL_MEASURE];
  assign WAKEUP_EN               = wake_mode;

  // a detector is live while enabled, running and armed
  assign act_live    = act_en & running & act_armed;
  assign inact_live  = inact_en & running & inact_armed;
  assign act_start   = act_live & ~act_live_q;
  assign inact_start = inact_live & ~inact_live_q;

  // linked mode keeps one detector armed; unlinked keeps both
  // the turn bit says which detector a linked pair waits on; leaving link
  // or standby always hands the turn back to activity, so turning link on
  // while both were armed never leaves inactivity armed as well
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      inact_turn_q <= 1'b0;
    end else if (!link_en || !running) begin
      inact_turn_q <= 1'b0;
    end else if (act_hit) begin
      inact_turn_q <= 1'b1;
    end else if (inact_hit) begin
      inact_turn_q <= 1'b0;
    end
  end

  // unlinked, the turn bit is ignored and both detectors stay armed
  assign act_armed   = ~link_en | ~inact_turn_q;
  assign inact_armed = ~link_en | inact_turn_q;

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      act_live_q   <= 1'b0;
      inact_live_q <= 1'b0;
    end else begin
      act_live_q   <= act_live;
      inact_live_q <= inact_live;
    end
  end

  // reference capture waits for the next sample; that sample is not judged,
  // so only a sample arriving in the cycle the capture is armed is compared against a stale reference
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      act_cap_q <= 1'b0;
    end else if (act_start) begin
      act_cap_q <= 1'b1;
    end else if (act_hit && !link_en) begin
      act_cap_q <= 1'b1;
    end else if (SAMPLE_VALID || !act_live) begin
      act_cap_q <= 1'b0;
    end
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      inact_cap_q <= 1'b0;
    end else if (inact_start || (inact_hit && !link_en)) begin
      inact_cap_q <= 1'b1;
    end else if (SAMPLE_VALID || !inact_live) begin
      inact_cap_q <= 1'b0;
    end
  end

  assign samples = {SAMPLE_Z, SAMPLE_Y, SAMPLE_X};

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
      axis_deviation_check #(
        .SW (SW),
        .TW (TW)
      ) u_act_axis (
        .clk           (REF_CLK),
        .rst_n         (rst_n),
        .sample_strobe (SAMPLE_VALID),
        .capture       (act_cap_q),
        .sample        (samples[ax*SW +: SW]),
        .referenced    (ctrl_q[`CTRL_ACT_REF]),
        .threshold     (act_thr_q),
        .exceed        (act_exceed[ax])
      );
      axis_deviation_check #(
        .SW (SW),
        .TW (TW)
      ) u_inact_axis (
        .clk           (REF_CLK),
        .rst_n         (rst_n),
        .sample_strobe (SAMPLE_VALID),
        .capture       (inact_cap_q),
        .sample        (samples[ax*SW +: SW]),
        .referenced    (ctrl_q[`CTRL_INACT_REF]),
        .threshold     (inact_thr_q),
        .exceed        (inact_exceed[ax])
      );
    end
  endgenerate

  // activity needs any axis above; inactivity needs every axis at or below
  assign act_qualify   = (|act_exceed) & ~act_cap_q;
  assign inact_qualify = ~(|inact_exceed) & ~inact_cap_q;

  // wakeup mode has no activity timer
  assign act_target = wake_mode ? {{(AW-1){1'b0}}, 1'b1} : act_time_q;

  sample_run_counter #(
    .CW (AW)
  ) u_act_run (
    .clk           (REF_CLK),
    .rst_n         (rst_n),
    .sample_strobe (SAMPLE_VALID),
    .armed         (act_live),
    .qualify       (act_qualify),
    .target        (act_target),
    .hit           (act_hit)
  );

  sample_run_counter #(
    .CW (ITW)
  ) u_inact_run (
    .clk           (REF_CLK),
    .rst_n         (rst_n),
    .sample_strobe (SAMPLE_VALID),
    .armed         (inact_live),
    .qualify       (inact_qualify),
    .target        (inact_time_q),
    .hit           (inact_hit)
  );

  // sticky event flags: a new event beats a status read in the same cycle
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      act_flag_q   <= 1'b0;
      inact_flag_q <= 1'b0;
    end else begin
      if (act_hit) begin
        act_flag_q <= 1'b1;
      end else if (rd_status) begin
        act_flag_q <= 1'b0;
      end
      if (inact_hit) begin
        inact_flag_q <= 1'b1;
      end else if (rd_status) begin
        inact_flag_q <= 1'b0;
      end
    end
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      awake_q <= `AWAKE_RESET;
    end else if (act_hit) begin
      awake_q <= 1'b1;
    end else if (inact_hit) begin
      awake_q <= 1'b0;
    end
  end

  assign status  = {awake_q, inact_flag_q, act_flag_q};
  assign INT_REQ = |(status & int_map_q);
  assign AWAKE   = awake_q;

  // read data appear the cycle after the strobe and only then
  always @* begin
    rdata_d = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        `REG_CTRL:         rdata_d[`CTRL_W-1:0] = ctrl_q;
        `REG_ACT_THRESH:   rdata_d[TW-1:0]      = act_thr_q;
        `REG_ACT_TIME:     rdata_d[AW-1:0]      = act_time_q;
        `REG_INACT_THRESH: rdata_d[TW-1:0]      = inact_thr_q;
        `REG_INACT_TIME:   rdata_d[ITW-1:0]     = inact_time_q;
        `REG_INT_MAP:      rdata_d[`ST_W-1:0]   = int_map_q;
        `REG_STATUS:       rdata_d[`ST_W-1:0]   = status;
        default:           rdata_d              = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

endmodule

`default_nettype wire

//--- motion_activity_detector_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module motion_activity_detector_chk (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RSTN,
  // register port
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // samples and results
  input wire logic        SAMPLE_VALID,
  input wire logic        FILTER_BANDWIDTH_SELECT,
  input wire logic [1:0]  NOISE_MODE,
  input wire logic        MEASURE_EN,
  input wire logic        WAKEUP_EN,
  input wire logic        INT_REQ,
  input wire logic        AWAKE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  rdata_idle_a: assert property (
    !$past(RD) |-> RDATA == 32'h0) else $error("read data not zero outside read cycle");
  bw_reset_a: assert property (
    $rose(RSTN) |-> !FILTER_BANDWIDTH_SELECT) else $error("bandwidth not quarter after reset");
  bw_follow_a: assert property (
    WR && ADDR == 8'h00 |=> FILTER_BANDWIDTH_SELECT == $past(WDATA[7])) else $error("bandwidth select wrong");
  noise_follow_a: assert property (
    WR && ADDR == 8'h00 |=> NOISE_MODE == $past(WDATA[6:5])) else $error("noise mode wrong");
  mode_follow_a: assert property (
    WR && ADDR == 8'h00 |=> {WAKEUP_EN, MEASURE_EN} == $past(WDATA[9:8])) else $error("mode bits wrong");
  // a detector only moves on a sample taken while a mode was running
  awake_rise_a: assert property (
    $rose(AWAKE) |-> $past(SAMPLE_VALID, 2) && ($past(MEASURE_EN, 2) || $past(WAKEUP_EN, 2)))
    else $error("awake set without a qualifying sample");
  awake_fall_a: assert property (
    $fell(AWAKE) |-> $past(SAMPLE_VALID, 2)) else $error("awake cleared without a sample");
  int_change_a: assert property (
    $changed(INT_REQ) |-> $past(WR) || $past(RD) || $past(SAMPLE_VALID, 2))
    else $error("interrupt moved without a cause");

  awake_rise_c: cover property ($rose(AWAKE));
  int_rise_c: cover property ($rose(INT_REQ));
  int_fall_c: cover property ($fell(INT_REQ));
endmodule

bind motion_activity_detector motion_activity_detector_chk u_motion_activity_detector_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SAMPLE_VALID(SAMPLE_VALID), .FILTER_BANDWIDTH_SELECT(FILTER_BANDWIDTH_SELECT),
  .NOISE_MODE(NOISE_MODE), .MEASURE_EN(MEASURE_EN), .WAKEUP_EN(WAKEUP_EN),
  .INT_REQ(INT_REQ), .AWAKE(AWAKE));

`default_nettype wire

//--- host_bus.sv
`timescale 1ns/10ps
`default_nettype none

module host_bus (
  // clock
  input  wire logic        clk,
  // register port
  output var  logic [7:0]  addr,
  output var  logic [31:0] wdata,
  output var  logic        wr,
  output var  logic        rd,
  input  wire logic [31:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // idle cycle after each strobe so no strobe is assigned twice in one step
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // a status read also clears the event flags
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    // taken at the edge that closes the one cycle in which the data stand
    d = rdata;
  endtask
endmodule

`default_nettype wire

//--- motion_activity_detector_test.sv
`timescale 1ns/10ps
`default_nettype none

module motion_activity_detector_test;
  logic        REF_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        SAMPLE_VALID = 1'b0;
  logic [35:0] smp_q = 36'h0;
  wire  [7:0]  ADDR;
  wire  [31:0] WDATA;
  wire  [31:0] RDATA;
  wire         WR;
  wire         RD;
  wire         FILTER_BANDWIDTH_SELECT;
  wire  [1:0]  NOISE_MODE;
  wire         MEASURE_EN;
  wire         WAKEUP_EN;
  wire         INT_REQ;
  wire         AWAKE;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #25 REF_CLK = ~REF_CLK;

  motion_activity_detector u_motion_activity_detector (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_X(smp_q[35:24]), .SAMPLE_Y(smp_q[23:12]), .SAMPLE_Z(smp_q[11:0]),
    .FILTER_BANDWIDTH_SELECT(FILTER_BANDWIDTH_SELECT), .NOISE_MODE(NOISE_MODE), .MEASURE_EN(MEASURE_EN),
    .WAKEUP_EN(WAKEUP_EN), .INT_REQ(INT_REQ), .AWAKE(AWAKE));

  host_bus u_host_bus (
    .clk(REF_CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));

  task automatic tally_and_finish;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_host_bus.get(a, d);
    chk(d, exp);
  endtask

  // one sample, then three idle edges so the flags have landed
  task automatic smp(input logic [35:0] s);
    smp_q <= s;
    SAMPLE_VALID <= 1'b1;
    @(posedge REF_CLK);
    SAMPLE_VALID <= 1'b0;
    repeat (3) @(posedge REF_CLK);
  endtask

  task automatic apply_reset;
    RSTN <= 1'b0;
    repeat (16) @(posedge REF_CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge REF_CLK);
  endtask

  task automatic t_cfg;
    chk({31'h0, FILTER_BANDWIDTH_SELECT}, 32'h0);
    rchk(8'h00, 32'h0);
    for (int n = 0; n < 3; n++) begin
      for (int b = 0; b < 2; b++) begin
        u_host_bus.put(8'h00, {24'h0, b[0], n[1:0], 5'h00});
        chk({31'h0, FILTER_BANDWIDTH_SELECT}, {31'h0, b[0]});
        chk({30'h0, NOISE_MODE}, {30'h0, n[1:0]});
      end
    end
    u_host_bus.put(8'h1c, 32'hffffffff);
    rchk(8'h1c, 32'h0);
  endtask

  task automatic t_act_abs;
    apply_reset;
    u_host_bus.put(8'h04, 32'd100);
    u_host_bus.put(8'h08, 32'd3);
    u_host_bus.put(8'h14, 32'h1);
    u_host_bus.put(8'h00, 32'h101);
    smp({12'h000, 12'h000, 12'h000});
    smp({12'h0c8, 12'h000, 12'h000});
    smp({12'h000, 12'h000, 12'he38});
    // exactly at the threshold is not above it, so the run restarts
    smp({12'h064, 12'h000, 12'h000});
    smp({12'h000, 12'h0c8, 12'h000});
    smp({12'he38, 12'h000, 12'h000});
    chk({31'h0, AWAKE}, 32'h0);
    smp({12'h0c8, 12'h000, 12'h000});
    chk({31'h0, AWAKE}, 32'h1);
    chk({31'h0, INT_REQ}, 32'h1);
    rchk(8'h18, 32'h5);
    rchk(8'h18, 32'h4);
    chk({31'h0, INT_REQ}, 32'h0);
  endtask

  task automatic t_inact_ref;
    apply_reset;
    u_host_bus.put(8'h0c, 32'd50);
    u_host_bus.put(8'h10, 32'd2);
    u_host_bus.put(8'h14, 32'h2);
    u_host_bus.put(8'h00, 32'h10c);
    smp({12'h3e8, 12'h000, 12'h000});
    smp({12'h410, 12'h000, 12'h000});
    smp({12'h424, 12'h000, 12'h000});
    rchk(8'h18, 32'h0);
    smp({12'h3f2, 12'h000, 12'h000});
    smp({12'h3de, 12'h000, 12'h000});
    chk({31'h0, INT_REQ}, 32'h1);
    rchk(8'h18, 32'h2);
  endtask

  task automatic t_wake_ref;
    apply_reset;
    u_host_bus.put(8'h04, 32'd100);
    u_host_bus.put(8'h08, 32'd4);
    u_host_bus.put(8'h00, 32'h1);
    smp({12'h1f4, 12'h000, 12'h000});
    smp({12'h1f4, 12'h000, 12'h000});
    rchk(8'h18, 32'h0);
    u_host_bus.put(8'h00, 32'h203);
    chk({30'h0, WAKEUP_EN, MEASURE_EN}, 32'h2);
    smp({12'h3e8, 12'h3e8, 12'h3e8});
    smp({12'h41a, 12'h3e8, 12'h3e8});
    rchk(8'h18, 32'h0);
    smp({12'h3e8, 12'h3e8, 12'h47e});
    rchk(8'h18, 32'h5);
    // unlinked repeat: the next sample is the new reference, so the same value no longer trips
    smp({12'h3e8, 12'h3e8, 12'h47e});
    smp({12'h3e8, 12'h3e8, 12'h47e});
    rchk(8'h18, 32'h4);
  endtask

  task automatic t_link;
    apply_reset;
    u_host_bus.put(8'h04, 32'd100);
    u_host_bus.put(8'h0c, 32'd50);
    u_host_bus.put(8'h14, 32'h4);
    u_host_bus.put(8'h00, 32'h117);
    chk({30'h0, WAKEUP_EN, MEASURE_EN}, 32'h1);
    smp({12'h000, 12'h000, 12'h000});
    smp({12'h0c8, 12'h000, 12'h000});
    chk({31'h0, AWAKE}, 32'h1);
    chk({31'h0, INT_REQ}, 32'h1);
    // inactivity only starts now, so this quiet sample falls in its capture cycle and is not judged
    smp({12'h000, 12'h000, 12'h000});
    smp({12'h0c8, 12'h000, 12'h000});
    rchk(8'h18, 32'h5);
    smp({12'h000, 12'h000, 12'h000});
    chk({31'h0, AWAKE}, 32'h0);
    chk({31'h0, INT_REQ}, 32'h0);
    rchk(8'h18, 32'h2);
    // the first sample after inactivity becomes the new activity reference
    smp({12'h3e8, 12'h000, 12'h000});
    smp({12'h41a, 12'h000, 12'h000});
    chk({31'h0, AWAKE}, 32'h0);
    smp({12'h4b0, 12'h000, 12'h000});
    chk({31'h0, AWAKE}, 32'h1);
  endtask

  initial begin
    @(posedge REF_CLK);
    apply_reset;
    t_cfg;
    t_act_abs;
    t_inact_ref;
    t_wake_ref;
    t_link;
    tally_and_finish;
  end

  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
